// *** hdl/umc_pkg.sv ***
// Purpose: constants for the serial-port modem-control block
// Assumes: 250 MHz ref_clk, plain register port, two ports
// Notes:   register offsets below are local choices
//
// Notes on behaviour
// R1 - send request pin low when control bit 1
// R2 - send request high during hardware reset
// R3 - loop mode forces send request inactive
// R4 - reset release samples port2 strap, picks base
// R5 - terminal ready pin low when control bit 0
// R6 - terminal ready high during hardware reset
// R7 - loop mode forces terminal ready inactive
// R8 - status bit 4 is inverted clear to send
// R9 - clear to send rise sets status bit 0
// R10 - clear to send never touches transmitter
// R11 - status bit 5 is inverted set ready
// R12 - set ready rise sets status bit 1
// R13 - status bit 7 is inverted carrier detect
// R14 - carrier detect rise sets status bit 3
// R15 - status bit 6 is inverted ring indicator
// R16 - ring indicator rise sets status bit 2
// R17 - enable bit 3 raises interrupt on changes
// R18 - status read clears deltas and interrupt
package umc_pkg;
	// ======================================================
	// register map (index per port = offset + 8*port)
	localparam logic [3:0] UMC_OFS_MCR  = 4'h0; // modem control
	localparam logic [3:0] UMC_OFS_MSR  = 4'h1; // modem status
	localparam logic [3:0] UMC_OFS_IER  = 4'h2; // interrupt enable
	localparam logic [3:0] UMC_OFS_ISTS = 4'h3; // sticky events
	localparam logic [3:0] UMC_OFS_IMSK = 4'h4; // event mask
	localparam logic [3:0] UMC_OFS_CFG  = 4'h5; // strap readback
	localparam int         UMC_PORT_SEL = 3;    // address bit: port
	// ======================================================
	// field positions
	localparam int UMC_MCR_DTR  = 0;
	localparam int UMC_MCR_RTS  = 1;
	localparam int UMC_MCR_LOOP = 4;
	localparam int UMC_IER_MS   = 3;
	localparam int UMC_MSR_DCTS = 0;
	localparam int UMC_MSR_DDSR = 1;
	localparam int UMC_MSR_TERI = 2;
	localparam int UMC_MSR_DDCD = 3;
	localparam int UMC_MSR_CTS  = 4;
	localparam int UMC_MSR_DSR  = 5;
	localparam int UMC_MSR_RI   = 6;
	localparam int UMC_MSR_DCD  = 7;
	localparam int UMC_IST_MS   = 0; // event: modem status change
	// ======================================================
	// reset values and bases
	localparam logic [7:0]  UMC_RST_BYTE = 8'h00;
	localparam logic [11:0] UMC_BASE_LO  = 12'h3F0;
	localparam logic [11:0] UMC_BASE_HI  = 12'h370;
endpackage

// *** hdl/umc_modem_ctrl.sv ***
// Purpose: modem control and status for two serial ports
// Assumes: pins synchronous to ref_clk
// Notes:   modem status inputs are active low; one interrupt per port
`timescale 1ns/1ps
module umc_modem_ctrl
	import umc_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// modem pins, index 0 = port 1
	output logic      [1:0]  send_request_n,
	output logic      [1:0]  terminal_ready_n,
	input  wire logic        port2_strap_in,
	input  wire logic [1:0]  clear_to_send_n,
	input  wire logic [1:0]  set_ready_n,
	input  wire logic [1:0]  carrier_detect_n,
	input  wire logic [1:0]  ring_indicator_n,
	// configuration and interrupts
	output logic      [11:0] config_base_strap,
	output logic      [1:0]  irq
);
	// ======================================================
	// state
	typedef struct packed {
		logic [1:0][7:0] modem_control_reg;   // modem control
		logic [1:0][3:0] delta; // change bits
		logic [1:0][3:0] prev;  // last pin levels, inverted
		logic [1:0][7:0] ier;   // interrupt enable
		logic [1:0][7:0] ists;  // sticky events
		logic [1:0][7:0] imsk;  // event mask
		logic            strap_done;
		logic            strap;
		logic [7:0]      rdata;
	} umc_state_type;

	umc_state_type st_reg;  // registered state
	umc_state_type st_next; // next state

	logic [1:0][3:0] cur; // inverted pins: cts,dsr,ri,dcd in msr order

	// pick a register at its offset
	function automatic logic hit(input logic [3:0] a,
		input logic [3:0] ofs);
		hit = (a[2:0] == ofs[2:0]);
	endfunction

	// ======================================================
	// next state
	always_comb begin
		logic p;
		logic [1:0][3:0] rise;
		logic [1:0]      change;
		// locals start defined on every pass
		rise = '0;
		change = '0;
		p = reg_addr[UMC_PORT_SEL];
		st_next = st_reg;
		for (int i = 0; i < 2; i++) begin
			// inverted pins in delta bit order 0..3
			cur[i] = {~carrier_detect_n[i], ~ring_indicator_n[i],
				~set_ready_n[i], ~clear_to_send_n[i]};
			// R9 R12 R14 R16 pin low->high = cur high->low
			rise[i] = st_reg.prev[i] & ~cur[i];
			change[i] = |(st_reg.prev[i] ^ cur[i]);
			st_next.prev[i] = cur[i];
		end
		// R18 status read clears deltas and pending
		if (reg_rd && hit(reg_addr, UMC_OFS_MSR)) begin
			st_next.delta[p] = 4'h0;
			st_next.ists[p][UMC_IST_MS] = 1'b0;
		end
		// register writes
		if (reg_wr) begin
			if (hit(reg_addr, UMC_OFS_MCR))
				st_next.modem_control_reg[p] = reg_wdata;
			if (hit(reg_addr, UMC_OFS_IER))
				st_next.ier[p] = reg_wdata;
			if (hit(reg_addr, UMC_OFS_IMSK))
				st_next.imsk[p] = reg_wdata;
			if (hit(reg_addr, UMC_OFS_ISTS))
				st_next.ists[p] = st_reg.ists[p] & ~reg_wdata;
		end
		// sets win over clears
		for (int i = 0; i < 2; i++) begin
			st_next.delta[i] = st_next.delta[i] | rise[i];
			// R17 change raises event when enabled
			if (change[i] && st_reg.ier[i][UMC_IER_MS])
				st_next.ists[i][UMC_IST_MS] = 1'b1;
		end
		// R4 catch strap at first edge after release
		if (!st_reg.strap_done) begin
			st_next.strap_done = 1'b1;
			st_next.strap = port2_strap_in;
		end
		// read data, valid in cycle after strobe
		st_next.rdata = UMC_RST_BYTE;
		if (reg_rd) begin
			if (hit(reg_addr, UMC_OFS_MCR))
				st_next.rdata = st_reg.modem_control_reg[p];
			else if (hit(reg_addr, UMC_OFS_MSR))
				// R8 R11 R13 R15 level bits inverted pins
				st_next.rdata = {cur[p][3], cur[p][2], cur[p][1],
					cur[p][0], st_reg.delta[p]};
			else if (hit(reg_addr, UMC_OFS_IER))
				st_next.rdata = st_reg.ier[p];
			else if (hit(reg_addr, UMC_OFS_ISTS))
				st_next.rdata = st_reg.ists[p];
			else if (hit(reg_addr, UMC_OFS_IMSK))
				st_next.rdata = st_reg.imsk[p];
			else if (hit(reg_addr, UMC_OFS_CFG))
				st_next.rdata = {7'h00, st_reg.strap};
		end
	end

	// ======================================================
	// state register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ======================================================
	// outputs
	// R10 no transmit gating exists here
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			// R1 R2 R3 low when bit set, high in reset or loop
			send_request_n[i] = !(arst_n && st_reg.modem_control_reg[i][UMC_MCR_RTS]
				&& !st_reg.modem_control_reg[i][UMC_MCR_LOOP]);
			// R5 R6 R7 same for terminal ready
			terminal_ready_n[i] = !(arst_n && st_reg.modem_control_reg[i][UMC_MCR_DTR]
				&& !st_reg.modem_control_reg[i][UMC_MCR_LOOP]);
			irq[i] = |(st_reg.ists[i] & st_reg.imsk[i]);
		end
		config_base_strap = st_reg.strap ? UMC_BASE_HI : UMC_BASE_LO;
		reg_rdata = st_reg.rdata;
	end

	// ======================================================
	// checks
	// R1 pin follows control bit
	a_rts_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!st_reg.modem_control_reg[0][UMC_MCR_LOOP] |-> send_request_n[0] ==
		!st_reg.modem_control_reg[0][UMC_MCR_RTS]) else $error("rts wrong"); // R1
	// R3 loop holds pin high
	a_rts_loop: assert property (@(posedge ref_clk) disable iff (!arst_n)
		st_reg.modem_control_reg[1][UMC_MCR_LOOP] |-> send_request_n[1])
		else $error("rts in loop"); // R3
	// R5 R7 terminal ready
	a_dtr_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
		terminal_ready_n[0] == !(st_reg.modem_control_reg[0][UMC_MCR_DTR] &&
		!st_reg.modem_control_reg[0][UMC_MCR_LOOP])) else $error("dtr wrong"); // R5
	// R9 rise sets delta
	a_cts_delta: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$rose(clear_to_send_n[0]) && st_reg.strap_done |=>
		st_reg.delta[0][UMC_MSR_DCTS]) else $error("no delta"); // R9
	// R18 read clears deltas
	a_read_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
		reg_rd && reg_addr == {1'b0, UMC_OFS_MSR[2:0]} &&
		$stable(cur[0]) |=> st_reg.delta[0] == 4'h0)
		else $error("no clear"); // R18
	// R8 status level bit
	a_msr_cts: assert property (@(posedge ref_clk) disable iff (!arst_n)
		reg_rd && reg_addr == {1'b0, UMC_OFS_MSR[2:0]} |=>
		reg_rdata[UMC_MSR_CTS] == !$past(clear_to_send_n[0]))
		else $error("cts level"); // R8
	// R17 change raises interrupt
	a_ms_irq: assert property (@(posedge ref_clk) disable iff (!arst_n)
		st_reg.ier[0][UMC_IER_MS] && st_reg.imsk[0][UMC_IST_MS] &&
		$changed(set_ready_n[0]) && st_reg.strap_done ##1 !reg_wr
		|-> irq[0]) else $error("no irq"); // R17
	// R4 strap sets base
	a_strap_base: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$rose(st_reg.strap_done) |-> config_base_strap ==
		($past(port2_strap_in) ? UMC_BASE_HI : UMC_BASE_LO))
		else $error("strap base"); // R4
	// R12 second port set ready rise sets delta
	a_dsr_delta: assert property (@(posedge ref_clk) disable iff (!arst_n) // R12
		$rose(set_ready_n[1]) && st_reg.strap_done |=>
		st_reg.delta[1][UMC_MSR_DDSR]) else $error("no dsr delta");
	// R13 second port carrier level bit
	a_msr_dcd: assert property (@(posedge ref_clk) disable iff (!arst_n) // R13
		reg_rd && reg_addr == {1'b1, UMC_OFS_MSR[2:0]} |=>
		reg_rdata[UMC_MSR_DCD] == !$past(carrier_detect_n[1]))
		else $error("dcd level");
	// R7 loop holds terminal ready high
	a_dtr_loop: assert property (@(posedge ref_clk) disable iff (!arst_n) // R7
		st_reg.modem_control_reg[1][UMC_MCR_LOOP] |-> terminal_ready_n[1])
		else $error("dtr in loop");
	c_irq: cover property (@(posedge ref_clk) disable iff (!arst_n)
		$rose(irq[0]));
	c_strap_hi: cover property (@(posedge ref_clk) disable iff (!arst_n)
		config_base_strap == UMC_BASE_HI);
	c_loop: cover property (@(posedge ref_clk) disable iff (!arst_n)
		st_reg.modem_control_reg[0][UMC_MCR_LOOP] && st_reg.modem_control_reg[0][UMC_MCR_RTS]);
	c_delta: cover property (@(posedge ref_clk) disable iff (!arst_n)
		st_reg.delta[1] == 4'hF);
endmodule // umc_modem_ctrl

// *** bench/umc_modem_model.sv ***
// Purpose: modem on the far side of the control pins
// Assumes: bench sets wanted pin levels after a clock edge
// Notes:   strap pin is a plain resistor level
`timescale 1ns/1ps
module umc_modem_model (
	// clock
	input  wire logic       ref_clk,
	// bench commands: per port {ri,dcd,dsr,cts}
	input  wire logic [7:0] want,
	input  wire logic       strap,
	// modem pins
	output logic      [1:0] cts_n,
	output logic      [1:0] dsr_n,
	output logic      [1:0] dcd_n,
	output logic      [1:0] ri_n,
	output logic            strap_pin
);
	// resistor on port2 send request pin
	assign strap_pin = strap;
	// modem moves its status lines one edge later
	always_ff @(posedge ref_clk) begin
		for (int p = 0; p < 2; p++) begin
			cts_n[p] <= want[4*p];
			dsr_n[p] <= want[4*p+1];
			dcd_n[p] <= want[4*p+2];
			ri_n[p]  <= want[4*p+3];
		end
	end
endmodule // umc_modem_model

// *** bench/umc_modem_ctrl_tb.sv ***
// Purpose: self-checking bench for the modem control block
// Assumes: 250 MHz clock, seed 10
// Notes:   pins mapped per port as {ri,dcd,dsr,cts}
`timescale 1ns/1ps
module umc_modem_ctrl_tb;
	import umc_pkg::*;
	logic        ref_clk = 1'h0, arst_n = 1'h0, strap = 1'h0;
	logic        reg_wr = 1'h0, reg_rd = 1'h0;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00, want = 8'hFF, old = 8'hFF, d;
	logic [7:0]  reg_rdata;
	logic [1:0]  rts_n, dtr_n, cts_n, dsr_n, dcd_n, ri_n, irq, m;
	logic        strap_pin;
	logic [11:0] base;
	int          n_fail = 0, n_tests = 0;
	// clock, 4 ns period
	always #2 ref_clk = ~ref_clk;
	umc_modem_model u_umc_modem_model (.ref_clk(ref_clk), .want(want),
		.strap(strap), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n),
		.ri_n(ri_n), .strap_pin(strap_pin));
	umc_modem_ctrl u_umc_modem_ctrl (.ref_clk(ref_clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .send_request_n(rts_n),
		.terminal_ready_n(dtr_n), .port2_strap_in(strap_pin),
		.clear_to_send_n(cts_n), .set_ready_n(dsr_n),
		.carrier_detect_n(dcd_n), .ring_indicator_n(ri_n),
		.config_base_strap(base), .irq(irq));
	// expected status byte from old and new pin levels
	function automatic logic [7:0] modem_status_reg(input logic [3:0] o, n);
		modem_status_reg = {~n[2], ~n[3], ~n[1], ~n[0],
			~o[2] & n[2], ~o[3] & n[3], ~o[1] & n[1], ~o[0] & n[0]};
	endfunction
	// compare and count
	task automatic chk(input string s, input logic [11:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	// one-cycle read strobe, data in the next cycle only
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 v = reg_rdata;
	endtask
	// verdict and end of run
	task automatic conclude;
		$display("counts: fail %0d tests %0d", n_fail, n_tests);
		if (n_fail == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// watchdog
	initial begin
		#100000 n_fail++;
		conclude();
	end
	// main sequence
	initial begin
		d = $urandom(10);
		repeat (12) @(posedge ref_clk);
		chk("rts in reset", 12'h3, rts_n);
		chk("dtr in reset", 12'h3, dtr_n);
		arst_n <= 1'h1;
		repeat (2) @(posedge ref_clk);
		#1 chk("base strap 0", 12'h3F0, base);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			d = (i == 0) ? 8'h13 : 8'($urandom);
			wr({i[0], UMC_OFS_MCR[2:0]}, d);
			@(posedge ref_clk);
			#1 chk("rts", !(d[1] && !d[4]), rts_n[i[0]]);
			chk("dtr", !(d[0] && !d[4]), dtr_n[i[0]]);
		end
		$display("test control pins done");
		for (int p = 0; p < 2; p++) begin
			wr({p[0], UMC_OFS_MCR[2:0]}, 8'h00);
			wr({p[0], UMC_OFS_IER[2:0]}, 8'h08);
			wr({p[0], UMC_OFS_IMSK[2:0]}, 8'h01);
			rd({p[0], UMC_OFS_MSR[2:0]}, d);
		end
		for (int i = 0; i < 24; i++) begin
			m = 2'($urandom) | 2'h1;
			wr({1'h1, UMC_OFS_IMSK[2:0]}, {7'h00, m[1]});
			want <= (i == 0) ? 8'h00 : 8'($urandom);
			repeat (3) @(posedge ref_clk);
			#1 chk("irq", {10'h000, m[1] && want[7:4] != old[7:4],
				want[3:0] != old[3:0]}, irq);
			for (int p = 0; p < 2; p++) begin
				rd({p[0], UMC_OFS_MSR[2:0]}, d);
				chk("msr", modem_status_reg(old[4*p+:4], want[4*p+:4]), d);
			end
			@(posedge ref_clk);
			#1 chk("irq after read", 12'h0, irq);
			old = want;
		end
		$display("test status done");
		want <= ~old;
		repeat (3) @(posedge ref_clk);
		#1 chk("irq set", 12'h1, irq[0]);
		rd({1'h0, UMC_OFS_ISTS[2:0]}, d);
		chk("ists", 12'h001, d);
		wr({1'h0, UMC_OFS_ISTS[2:0]}, 8'h01);
		@(posedge ref_clk);
		#1 chk("irq after clear", 12'h0, irq[0]);
		rd({1'h0, UMC_OFS_ISTS[2:0]}, d);
		chk("ists cleared", 12'h000, d);
		rd({1'h0, UMC_OFS_MSR[2:0]}, d);
		chk("msr flip", modem_status_reg(old[3:0], ~old[3:0]), d);
		old = ~old;
		$display("test event clear done");
		rd(4'h6, d);
		chk("unmapped", 12'h0, d);
		strap <= 1'h1;
		arst_n <= 1'h0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'h1;
		repeat (2) @(posedge ref_clk);
		#1 chk("base strap 1", 12'h370, base);
		rd({1'h0, UMC_OFS_CFG[2:0]}, d);
		chk("strap readback", 12'h001, d);
		$display("test strap done");
		conclude();
	end
endmodule // umc_modem_ctrl_tb
